// file: rtl/smp_params.svh
/*
 Constants of the message and pointer control block: message codes, pointer and
 logical unit widths. Assumes it is included by bare name wherever a constant is needed.
*/
// Overview of operation
// - Initiator keeps one current pointer set.
// - Saved command/data/status pointers kept per command.
// - Saved data starts at data area; save copies.
// - Restore loads every current pointer from saved.
// - Disconnect keeps saved only; reload at reconnect.
// - Command complete supported; target then releases busy.
// - Initiator asserts attention before selection.
// - Target answers attention with message-out after selection.
// - Initiator first message is identify, abort or reset.
// - Target sends identify first after reselection.
// - One logical unit per selection until bus free.
// - Connect or reconnect performs implied restore.
// - Any message support implies message reject.
// - Decode 00-0C defined, 0D-7F reserved, bit7 identify.
// - Each message code travels only its allowed direction.
// - 01 only as extended message leading byte.
// - Disconnect goes out on the release edge; initiator does not save.
// - Unexpected bus free flags catastrophic error.
// - Target dropping bus silently discards its command.
// - Target sends save pointer before split disconnect.
// - After error report, restore or reconnect recovers pointers.
// - Abort with unit identified discards data, frees bus.
`ifndef SMP_PARAMS_SVH
`define SMP_PARAMS_SVH
`define SMP_PTR_W 32
`define SMP_LUN_W 3
`define SMP_NUM_LUN 8
`define SMP_PTR_STEP 32'h0000_0001
`define SMP_PTR_ZERO 32'h0000_0000
`define SMP_MSG_COMPLETE 8'h00
`define SMP_MSG_EXTENDED 8'h01
`define SMP_MSG_SAVE 8'h02
`define SMP_MSG_RESTORE 8'h03
`define SMP_MSG_DISCONNECT 8'h04
`define SMP_MSG_INIT_ERR 8'h05
`define SMP_MSG_ABORT 8'h06
`define SMP_MSG_REJECT 8'h07
`define SMP_MSG_NOP 8'h08
`define SMP_MSG_PARITY 8'h09
`define SMP_MSG_LINKED 8'h0A
`define SMP_MSG_LINKED_FLAG 8'h0B
`define SMP_MSG_DEV_RESET 8'h0C
`define SMP_MSG_IDENTIFY 8'h80
`define SMP_ID_BIT 7
`define SMP_DISC_BIT 6
`endif

// file: rtl/smp_pkg.sv
/*
 Types and message decoding shared by both ends of the message link.
 Assumes smp_params.svh is on the include path.
*/
`include "smp_params.svh"
package smp_pkg;
	typedef logic [`SMP_PTR_W-1:0] smp_ptr_t;
	typedef logic [`SMP_LUN_W-1:0] smp_lun_t;
	typedef logic [7:0] smp_msg_t;

	// Codes that a target may send.
	function automatic logic smp_in_ok(input smp_msg_t m);
		smp_in_ok = m[`SMP_ID_BIT] || m == `SMP_MSG_COMPLETE || m == `SMP_MSG_SAVE
			|| m == `SMP_MSG_RESTORE || m == `SMP_MSG_DISCONNECT || m == `SMP_MSG_REJECT
			|| m == `SMP_MSG_LINKED || m == `SMP_MSG_LINKED_FLAG || m == `SMP_MSG_EXTENDED;
	endfunction

	// Codes that an initiator may send.
	function automatic logic smp_out_ok(input smp_msg_t m);
		smp_out_ok = m[`SMP_ID_BIT] || m == `SMP_MSG_INIT_ERR || m == `SMP_MSG_ABORT
			|| m == `SMP_MSG_REJECT || m == `SMP_MSG_NOP || m == `SMP_MSG_PARITY
			|| m == `SMP_MSG_DEV_RESET || m == `SMP_MSG_EXTENDED;
	endfunction
endpackage

// file: rtl/smp_link_if.sv
/*
 Logic-level message link between initiator and target. Both ends share one clock;
 every signal is driven from a flip-flop of its owner.
*/
`timescale 1ns/1ns
`default_nettype none
interface smp_link_if;
	import smp_pkg::*;
	logic sel;
	logic atn;
	logic busRst;
	logic msgOutValid;
	smp_msg_t msgOutByte;
	logic bsy;
	logic resel;
	logic msgOutReq;
	logic msgInValid;
	smp_msg_t msgInByte;
	modport initiator(output sel, atn, busRst, msgOutValid, msgOutByte,
		input bsy, resel, msgOutReq, msgInValid, msgInByte);
	modport target(input sel, atn, busRst, msgOutValid, msgOutByte,
		output bsy, resel, msgOutReq, msgInValid, msgInByte);
endinterface
`default_nettype wire

// file: rtl/smp_target.sv
/*
 Target end: answers selection, takes message-out bytes, sends message-in bytes.
 Assumes the initiator end on the same clock and a user that issues one send at a time.
*/
`timescale 1ns/1ns
`default_nettype none
`include "smp_params.svh"
module smp_target(
	input wire logic clock,
	input wire logic reset,
	smp_link_if.target link,
	input wire logic reselReq,
	input wire smp_pkg::smp_lun_t reselLun,
	input wire logic sendReq,
	input wire smp_pkg::smp_msg_t sendCode,
	input wire logic splitXfer,
	input wire logic abandonReq,
	output logic connected,
	output smp_pkg::smp_lun_t lunOut,
	output logic lunValid,
	output logic discardPulse,
	output logic clearAllPulse,
	output logic errRptPulse,
	output logic rejectSeenPulse
);
	import smp_pkg::*;
	typedef enum {T_IDLE, T_RESEL, T_CONN} smp_tstate_t;
	smp_tstate_t state_reg;
	logic bsy_reg, resel_reg, outReq_reg, inValid_reg, firstMsg_reg, pendDisc_reg;
	smp_msg_t inByte_reg;

	wire smp_msg_t mo = link.msgOutByte;
	wire moTaken = state_reg == T_CONN && link.msgOutValid;
	wire moIdent = mo[`SMP_ID_BIT];
	wire moFirstOk = moIdent || mo == `SMP_MSG_ABORT || mo == `SMP_MSG_DEV_RESET;
	wire moNewLun = lunValid && mo[`SMP_LUN_W-1:0] != lunOut;
	// Only target-to-initiator codes may be sent by the user; others are dropped.
	wire userOk = sendReq && state_reg == T_CONN && !pendDisc_reg && smp_in_ok(sendCode)
		&& !sendCode[`SMP_ID_BIT] && sendCode != `SMP_MSG_EXTENDED;
	wire releases = sendCode == `SMP_MSG_COMPLETE || sendCode == `SMP_MSG_DISCONNECT;

	assign link.bsy = bsy_reg;
	assign link.resel = resel_reg;
	assign link.msgOutReq = outReq_reg;
	assign link.msgInValid = inValid_reg;
	assign link.msgInByte = inByte_reg;

	always_ff @(posedge clock) begin
		discardPulse <= 1'b0;
		clearAllPulse <= 1'b0;
		errRptPulse <= 1'b0;
		rejectSeenPulse <= 1'b0;
		inValid_reg <= 1'b0;
		if (reset || link.busRst) begin
			state_reg <= T_IDLE;
			bsy_reg <= 1'b0;
			resel_reg <= 1'b0;
			outReq_reg <= 1'b0;
			inByte_reg <= `SMP_MSG_COMPLETE;
			firstMsg_reg <= 1'b0;
			pendDisc_reg <= 1'b0;
			connected <= 1'b0;
			lunOut <= '0;
			lunValid <= 1'b0;
		end else begin
			case (state_reg)
			T_IDLE: begin
				if (link.sel && !bsy_reg) begin
					bsy_reg <= 1'b1;
					connected <= 1'b1;
					firstMsg_reg <= 1'b1;
					lunValid <= 1'b0;
					state_reg <= T_CONN;
				end else if (reselReq) begin
					bsy_reg <= 1'b1;
					resel_reg <= 1'b1;
					connected <= 1'b1;
					lunOut <= reselLun;
					state_reg <= T_RESEL;
				end
			end
			T_RESEL: begin
				resel_reg <= 1'b0;
				inValid_reg <= 1'b1;
				inByte_reg <= `SMP_MSG_IDENTIFY | smp_msg_t'(lunOut);
				lunValid <= 1'b1;
				state_reg <= T_CONN;
			end
			T_CONN: begin
				// Attention is served only once selection is over.
				if (link.atn && !link.sel && !outReq_reg && !moTaken)
					outReq_reg <= 1'b1;
				if (pendDisc_reg) begin
					pendDisc_reg <= 1'b0;
					inValid_reg <= 1'b1;
					inByte_reg <= `SMP_MSG_DISCONNECT;
					bsy_reg <= 1'b0;
					connected <= 1'b0;
					state_reg <= T_IDLE;
				end else if (userOk) begin
					inValid_reg <= 1'b1;
					if (sendCode == `SMP_MSG_DISCONNECT && splitXfer) begin
						inByte_reg <= `SMP_MSG_SAVE;
						pendDisc_reg <= 1'b1;
					end else begin
						inByte_reg <= sendCode;
						if (releases) begin
							bsy_reg <= 1'b0;
							connected <= 1'b0;
							state_reg <= T_IDLE;
						end
					end
				end else if (abandonReq) begin
					bsy_reg <= 1'b0;
					connected <= 1'b0;
					discardPulse <= 1'b1;
					state_reg <= T_IDLE;
				end
				if (moTaken) begin
					outReq_reg <= 1'b0;
					firstMsg_reg <= 1'b0;
					if ((firstMsg_reg && !moFirstOk) || !smp_out_ok(mo) || mo == `SMP_MSG_EXTENDED
						|| (moIdent && moNewLun)) begin
						// Unknown, wrong-way, extended and second-unit bytes are refused.
						inValid_reg <= 1'b1;
						inByte_reg <= `SMP_MSG_REJECT;
					end else if (moIdent) begin
						lunOut <= mo[`SMP_LUN_W-1:0];
						lunValid <= 1'b1;
					end else if (mo == `SMP_MSG_ABORT || mo == `SMP_MSG_DEV_RESET) begin
						discardPulse <= lunValid && mo == `SMP_MSG_ABORT;
						clearAllPulse <= mo == `SMP_MSG_DEV_RESET;
						bsy_reg <= 1'b0;
						connected <= 1'b0;
						pendDisc_reg <= 1'b0;
						state_reg <= T_IDLE;
					end else if (mo == `SMP_MSG_INIT_ERR || mo == `SMP_MSG_PARITY) begin
						errRptPulse <= 1'b1;
					end else if (mo == `SMP_MSG_REJECT) begin
						rejectSeenPulse <= 1'b1;
					end
				end
			end
			default: state_reg <= T_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: rtl/smp_initiator.sv
/*
 Initiator end: selection with attention, outgoing message byte, incoming message
 decoding and the current and per-unit saved pointer sets.
 Assumes the target end on the same clock; pointer advances come from the data mover.
*/
`timescale 1ns/1ns
`default_nettype none
`include "smp_params.svh"
module smp_initiator(
	input wire logic clock,
	input wire logic reset,
	smp_link_if.initiator link,
	input wire logic selReq,
	input wire smp_pkg::smp_lun_t selLun,
	input wire logic selDisc,
	input wire smp_pkg::smp_ptr_t cmdBase,
	input wire smp_pkg::smp_ptr_t dataBase,
	input wire smp_pkg::smp_ptr_t statBase,
	input wire logic advCmd,
	input wire logic advData,
	input wire logic advStat,
	input wire logic errReport,
	input wire logic abortReq,
	input wire logic busRstReq,
	output smp_pkg::smp_ptr_t curCmdPtr,
	output smp_pkg::smp_ptr_t curDataPtr,
	output smp_pkg::smp_ptr_t curStatPtr,
	output logic connected,
	output smp_pkg::smp_lun_t curLun,
	output logic catastrophic,
	output logic cmdDone,
	output logic linkedDone,
	output logic rejectSeen
);
	import smp_pkg::*;
	typedef enum {I_IDLE, I_ATN, I_SEL, I_RESEL, I_CONN} smp_istate_t;
	smp_istate_t state_reg;
	// One saved set per logical unit; one command is active per unit.
	smp_ptr_t savedCmd[`SMP_NUM_LUN];
	smp_ptr_t savedData[`SMP_NUM_LUN];
	smp_ptr_t savedStat[`SMP_NUM_LUN];
	logic sel_reg, atn_reg, busRst_reg, outValid_reg, pend_reg, expectFree_reg, identified_reg;
	smp_msg_t outByte_reg, pendByte_reg;

	wire smp_msg_t mi = link.msgInByte;
	wire miTaken = link.msgInValid && (state_reg == I_CONN || state_reg == I_RESEL);
	wire miIdent = mi[`SMP_ID_BIT];
	wire smp_lun_t miLun = mi[`SMP_LUN_W-1:0];
	wire miSecondLun = identified_reg && miLun != curLun;
	wire miBad = !smp_in_ok(mi) || mi == `SMP_MSG_EXTENDED || (miIdent && miSecondLun)
		|| (state_reg == I_RESEL && !miIdent);
	wire busGone = (state_reg == I_CONN || state_reg == I_RESEL) && !link.bsy;
	// The target drops busy on the edge that sends its closing byte, so both arrive together;
	// judging the byte there keeps a clean disconnect from counting as a lost connection.
	wire miEnds = miTaken && !miBad && (mi == `SMP_MSG_COMPLETE || mi == `SMP_MSG_DISCONNECT);
	wire sendNow = pend_reg && link.msgOutReq && !outValid_reg;
	wire idleSel = state_reg == I_IDLE && selReq && !link.bsy;

	assign link.sel = sel_reg;
	assign link.atn = atn_reg;
	assign link.busRst = busRst_reg;
	assign link.msgOutValid = outValid_reg;
	assign link.msgOutByte = outByte_reg;

	// Saved pointers: written at command start and on save (data pointer only).
	always_ff @(posedge clock) begin
		if (idleSel) begin
			savedCmd[selLun] <= cmdBase;
			savedData[selLun] <= dataBase;
			savedStat[selLun] <= statBase;
		end else if (miTaken && !miBad && mi == `SMP_MSG_SAVE) begin
			savedData[curLun] <= curDataPtr;
		end
	end

	always_ff @(posedge clock) begin
		outValid_reg <= 1'b0;
		busRst_reg <= 1'b0;
		cmdDone <= 1'b0;
		linkedDone <= 1'b0;
		rejectSeen <= 1'b0;
		if (reset) begin
			state_reg <= I_IDLE;
			sel_reg <= 1'b0;
			atn_reg <= 1'b0;
			pend_reg <= 1'b0;
			pendByte_reg <= `SMP_MSG_NOP;
			outByte_reg <= `SMP_MSG_NOP;
			expectFree_reg <= 1'b0;
			identified_reg <= 1'b0;
			connected <= 1'b0;
			curLun <= '0;
			catastrophic <= 1'b0;
			curCmdPtr <= `SMP_PTR_ZERO;
			curDataPtr <= `SMP_PTR_ZERO;
			curStatPtr <= `SMP_PTR_ZERO;
		end else if (busRstReq) begin
			// A bus reset clears the link; the bus free that follows is not an error.
			busRst_reg <= 1'b1;
			state_reg <= I_IDLE;
			sel_reg <= 1'b0;
			atn_reg <= 1'b0;
			pend_reg <= 1'b0;
			expectFree_reg <= 1'b0;
			identified_reg <= 1'b0;
			connected <= 1'b0;
		end else begin
			if (sendNow) begin
				outValid_reg <= 1'b1;
				outByte_reg <= pendByte_reg;
				pend_reg <= 1'b0;
				atn_reg <= 1'b0;
			end
			case (state_reg)
			I_IDLE: begin
				if (idleSel) begin
					// Attention goes up one cycle ahead of select.
					atn_reg <= 1'b1;
					pend_reg <= 1'b1;
					pendByte_reg <= `SMP_MSG_IDENTIFY | (smp_msg_t'(selDisc) << `SMP_DISC_BIT) | smp_msg_t'(selLun);
					curLun <= selLun;
					catastrophic <= 1'b0;
					state_reg <= I_ATN;
				end else if (link.resel && link.bsy) begin
					connected <= 1'b1;
					state_reg <= I_RESEL;
				end
			end
			I_ATN: begin
				sel_reg <= 1'b1;
				state_reg <= I_SEL;
			end
			I_SEL: begin
				if (link.bsy) begin
					sel_reg <= 1'b0;
					connected <= 1'b1;
					identified_reg <= 1'b1;
					curCmdPtr <= savedCmd[curLun];
					curDataPtr <= savedData[curLun];
					curStatPtr <= savedStat[curLun];
					state_reg <= I_CONN;
				end
			end
			I_RESEL, I_CONN: begin
				if (busGone) begin
					// Only the saved set survives the bus going free.
					// A closing byte that lands with the release still counts as received first.
					catastrophic <= catastrophic || !(expectFree_reg || miEnds);
					cmdDone <= miEnds && mi == `SMP_MSG_COMPLETE;
					expectFree_reg <= 1'b0;
					identified_reg <= 1'b0;
					connected <= 1'b0;
					pend_reg <= 1'b0;
					atn_reg <= 1'b0;
					curCmdPtr <= `SMP_PTR_ZERO;
					curDataPtr <= `SMP_PTR_ZERO;
					curStatPtr <= `SMP_PTR_ZERO;
					state_reg <= I_IDLE;
				end else if (miTaken) begin
					if (miBad) begin
						pend_reg <= 1'b1;
						pendByte_reg <= `SMP_MSG_REJECT;
						atn_reg <= 1'b1;
					end else if (miIdent) begin
						curLun <= miLun;
						identified_reg <= 1'b1;
						curCmdPtr <= savedCmd[miLun];
						curDataPtr <= savedData[miLun];
						curStatPtr <= savedStat[miLun];
						state_reg <= I_CONN;
					end else begin
						case (mi)
						`SMP_MSG_COMPLETE: begin
							expectFree_reg <= 1'b1;
							cmdDone <= 1'b1;
						end
						`SMP_MSG_DISCONNECT: expectFree_reg <= 1'b1;
						`SMP_MSG_RESTORE, `SMP_MSG_LINKED, `SMP_MSG_LINKED_FLAG: begin
							curCmdPtr <= savedCmd[curLun];
							curDataPtr <= savedData[curLun];
							curStatPtr <= savedStat[curLun];
							linkedDone <= mi != `SMP_MSG_RESTORE;
						end
						`SMP_MSG_REJECT: rejectSeen <= 1'b1;
						default: ;
						endcase
					end
				end else begin
					if (advCmd)
						curCmdPtr <= curCmdPtr + `SMP_PTR_STEP;
					if (advData)
						curDataPtr <= curDataPtr + `SMP_PTR_STEP;
					if (advStat)
						curStatPtr <= curStatPtr + `SMP_PTR_STEP;
					if (!pend_reg && state_reg == I_CONN && (errReport || abortReq)) begin
						pend_reg <= 1'b1;
						atn_reg <= 1'b1;
						pendByte_reg <= abortReq ? `SMP_MSG_ABORT : `SMP_MSG_INIT_ERR;
						expectFree_reg <= expectFree_reg || abortReq;
					end
				end
			end
			default: state_reg <= I_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: test/smp_link_monitor.sv
/*
 Concurrent checks on the message link that joins the initiator and target ends.
 Assumes both ends share one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module smp_link_monitor(
	input wire logic clock,
	input wire logic reset,
	input wire logic sel,
	input wire logic atn,
	input wire logic busRst,
	input wire logic msgOutValid,
	input wire smp_pkg::smp_msg_t msgOutByte,
	input wire logic bsy,
	input wire logic resel,
	input wire logic msgOutReq,
	input wire logic msgInValid,
	input wire smp_pkg::smp_msg_t msgInByte
);
	import smp_pkg::*;
	logic firstPending_reg;
	logic firstPending_next;
	// Armed by selection, so that only the opening byte after it is judged.
	assign firstPending_next = sel | (firstPending_reg & ~msgOutValid);
	always_ff @(posedge clock) begin
		if (reset) begin
			firstPending_reg <= 1'b0;
		end else begin
			firstPending_reg <= firstPending_next;
		end
	end
	default clocking mcb @(posedge clock); endclocking
	default disable iff (reset);
	sel_needs_atn_a: assert property (sel |-> atn)
		else $error("select raised without attention");
	sel_gets_busy_a: assert property ($rose(sel) |=> bsy)
		else $error("target did not answer selection");
	atn_answered_a: assert property ($rose(bsy) && sel && atn |-> ##2 msgOutReq)
		else $error("attention not answered with message out");
	first_out_id_a: assert property (msgOutValid && firstPending_reg |->
		msgOutByte[7] || msgOutByte == 8'h06 || msgOutByte == 8'h0C)
		else $error("first byte after selection not identify");
	resel_first_id_a: assert property (resel |=> msgInValid && msgInByte[7])
		else $error("reselection not followed by identify");
	in_direction_a: assert property (msgInValid |-> msgInByte[7]
		|| msgInByte inside {8'h00, 8'h02, 8'h03, 8'h04, 8'h07, 8'h0A, 8'h0B})
		else $error("illegal target to initiator code");
	out_direction_a: assert property (msgOutValid |-> msgOutByte[7]
		|| msgOutByte inside {8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0C})
		else $error("illegal initiator to target code");
	complete_frees_a: assert property (msgInValid && msgInByte inside {8'h00, 8'h04} |-> !bsy)
		else $error("busy held after ending message");
	abort_frees_a: assert property (msgOutValid && msgOutByte == 8'h06 |-> ##[1:3] !bsy)
		else $error("busy held after abort");
	bus_reset_frees_a: assert property (busRst |=> !bsy)
		else $error("busy held after bus reset");
	cover property (busRst);
	cover property ($rose(sel));
	cover property (resel);
	cover property (msgInValid && msgInByte == 8'h00);
	cover property (msgOutValid && msgOutByte == 8'h06);
endmodule
`default_nettype wire

// file: test/scsi_message_pointer_control_test.sv
/*
 Self-checking bench joining both ends over the link interface, with random pointer bases.
 Assumes the design files and smp_pkg are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module scsi_message_pointer_control_test;
	import smp_pkg::*;
	logic clock, reset, selReq, selDisc, advCmd, advData, advStat, errReport, abortReq, busRstReq;
	logic reselReq, sendReq, splitXfer, abandonReq;
	logic iConn, tConn, catastrophic, cmdDone, linkedDone, rejectSeen, lunValid;
	logic discardPulse, clearAllPulse, errRptPulse, rejectSeenPulse;
	smp_lun_t selLun, reselLun, curLun, lunOut, lun;
	smp_ptr_t cmdBase, dataBase, statBase, curCmdPtr, curDataPtr, curStatPtr, expData;
	smp_msg_t sendCode;
	int numErrors = 0, samplesChecked = 0, nDone = 0, nLinked = 0, nDiscard = 0, nErrRpt = 0, nReject = 0, n;
	logic [31:0] rnd = 32'h8c40_fae5;
	smp_link_if linkBus();
	smp_initiator smp_initiator_inst(.clock(clock), .reset(reset), .link(linkBus), .selReq(selReq),
		.selLun(selLun), .selDisc(selDisc), .cmdBase(cmdBase), .dataBase(dataBase), .statBase(statBase),
		.advCmd(advCmd), .advData(advData), .advStat(advStat), .errReport(errReport), .abortReq(abortReq),
		.busRstReq(busRstReq), .curCmdPtr(curCmdPtr), .curDataPtr(curDataPtr), .curStatPtr(curStatPtr),
		.connected(iConn), .curLun(curLun), .catastrophic(catastrophic), .cmdDone(cmdDone),
		.linkedDone(linkedDone), .rejectSeen(rejectSeen));
	smp_target smp_target_inst(.clock(clock), .reset(reset), .link(linkBus), .reselReq(reselReq),
		.reselLun(reselLun), .sendReq(sendReq), .sendCode(sendCode), .splitXfer(splitXfer),
		.abandonReq(abandonReq), .connected(tConn), .lunOut(lunOut), .lunValid(lunValid),
		.discardPulse(discardPulse), .clearAllPulse(clearAllPulse), .errRptPulse(errRptPulse),
		.rejectSeenPulse(rejectSeenPulse));
	smp_link_monitor smp_link_monitor_inst(.clock(clock), .reset(reset), .sel(linkBus.sel), .atn(linkBus.atn),
		.busRst(linkBus.busRst), .msgOutValid(linkBus.msgOutValid), .msgOutByte(linkBus.msgOutByte),
		.bsy(linkBus.bsy), .resel(linkBus.resel), .msgOutReq(linkBus.msgOutReq),
		.msgInValid(linkBus.msgInValid), .msgInByte(linkBus.msgInByte));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Each advance pulse moves a pointer by one byte.
	function automatic smp_ptr_t expPtr(input smp_ptr_t base, input int steps);
		return base + smp_ptr_t'(steps);
	endfunction
	task tallyAndFinish;
		if (numErrors == 0 && samplesChecked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			numErrors++;
			$display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic checkFlag(input logic got, input logic exp);
		samplesChecked++;
		if (got !== exp) begin
			numErrors++;
			$display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic pulse(ref logic s);
		@(negedge clock);
		s = 1'b1;
		@(negedge clock);
		s = 1'b0;
	endtask
	task automatic waitConn(input logic v);
		for (int i = 0; i < 64 && iConn !== v; i++) @(negedge clock);
		checkFlag(iConn, v);
		if (iConn !== v) tallyAndFinish();
	endtask
	task automatic waitCnt(ref int c, input int exp);
		for (int i = 0; i < 64 && c < exp; i++) @(negedge clock);
		checkVal(32'(c), 32'(exp));
		if (c < exp) tallyAndFinish();
	endtask
	task automatic adv(input int steps);
		@(negedge clock);
		{advCmd, advData, advStat} = 3'b111;
		repeat (steps) @(negedge clock);
		{advCmd, advData, advStat} = 3'b000;
	endtask
	task automatic send(input smp_msg_t code);
		sendCode = code;
		pulse(sendReq);
		repeat (3) @(negedge clock);
	endtask
	task automatic selectLun;
		lun = rnd[2:0];
		selLun = lun;
		cmdBase = lfsr(rnd);
		dataBase = lfsr(cmdBase);
		statBase = lfsr(dataBase);
		rnd = lfsr(statBase);
		pulse(selReq);
		waitConn(1'b1);
		repeat (4) @(negedge clock);
		checkVal(curCmdPtr, cmdBase);
		checkVal(curDataPtr, dataBase);
		checkVal(curStatPtr, statBase);
		checkVal(32'(lunOut), 32'(lun));
		checkVal(32'(curLun), 32'(lun));
		checkFlag(tConn, 1'b1);
		checkFlag(lunValid, 1'b1);
	endtask
	task automatic reselect;
		reselLun = lun;
		pulse(reselReq);
		waitConn(1'b1);
		repeat (2) @(negedge clock);
	endtask
	always @(posedge clock) begin
		nDone += int'(cmdDone === 1'b1);
		nLinked += int'(linkedDone === 1'b1);
		nDiscard += int'(discardPulse === 1'b1);
		nErrRpt += int'(errRptPulse === 1'b1);
		nReject += int'(rejectSeen === 1'b1);
	end
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		reset = 1'b1;
		{selReq, selDisc, advCmd, advData, advStat, errReport, abortReq, busRstReq} = 8'h40;
		{reselReq, sendReq, splitXfer, abandonReq} = 4'h0;
		{selLun, reselLun, sendCode} = 14'h0000;
		{cmdBase, dataBase, statBase} = 96'h0;
		repeat (17) @(negedge clock);
		reset = 1'b0;
		for (int k = 0; k < 2; k++) begin
			selectLun();
			n = 1 + int'(rnd[1:0]);
			expData = expPtr(dataBase, n);
			adv(n);
			checkVal(curDataPtr, expData);
			send(8'h02);
			adv(2);
			send(8'h03);
			checkVal(curDataPtr, expData);
			checkVal(curCmdPtr, cmdBase);
			adv(1);
			pulse(errReport);
			waitCnt(nErrRpt, k + 1);
			send(8'h03);
			checkVal(curDataPtr, expData);
			adv(3);
			send(8'h04);
			waitConn(1'b0);
			checkFlag(catastrophic, 1'b0);
			checkVal(curDataPtr, 32'h0000_0000);
			reselect();
			checkVal(curDataPtr, expData);
			adv(2);
			expData = expPtr(expData, 2);
			splitXfer = 1'b1;
			send(8'h04);
			splitXfer = 1'b0;
			waitConn(1'b0);
			reselect();
			checkVal(curDataPtr, expData);
			adv(1);
			send(8'h0A);
			adv(1);
			send(8'h0B);
			checkVal(curDataPtr, expData);
			checkVal(32'(nLinked), 32'(2 * k + 2));
			send(8'h07);
			checkVal(32'(nReject), 32'(k + 1));
			send(8'h00);
			waitConn(1'b0);
			checkFlag(catastrophic, 1'b0);
			checkVal(32'(nDone), 32'(k + 1));
		end
		selectLun();
		pulse(abandonReq);
		waitConn(1'b0);
		checkFlag(catastrophic, 1'b1);
		waitCnt(nDiscard, 1);
		selectLun();
		pulse(abortReq);
		waitConn(1'b0);
		checkFlag(catastrophic, 1'b0);
		waitCnt(nDiscard, 2);
		// A bus reset frees the bus on purpose, so no error may follow it.
		selectLun();
		pulse(busRstReq);
		waitConn(1'b0);
		checkFlag(catastrophic, 1'b0);
		repeat (2) @(negedge clock);
		checkFlag(tConn, 1'b0);
		tallyAndFinish();
	end
endmodule
`default_nettype wire
